/* File: ptm_cfg.svh */
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the period timer module and bench top module only
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH

// Register indices on the 3-bit address port
`define PTM_ADDR_CTRL   3'h0
`define PTM_ADDR_SCALE  3'h1
`define PTM_ADDR_PERIOD 3'h2
`define PTM_ADDR_COUNT  3'h3
`define PTM_ADDR_PWCMP  3'h4
`define PTM_ADDR_STATUS 3'h5

// Control register fields
`define PTM_CTRL_ON     7
`define PTM_CTRL_MODE_H 4
`define PTM_CTRL_MODE_L 0

// Scale register fields
`define PTM_SCL_PRE_H   1
`define PTM_SCL_PRE_L   0
`define PTM_SCL_POST_H  5
`define PTM_SCL_POST_L  2
`define PTM_SCL_INSTR   6

// Status register fields
`define PTM_ST_PWM      0
`define PTM_ST_ARMED    1
`define PTM_ST_EXT      2
`define PTM_ST_ON       3

// Reset values
`define PTM_RST_MODE    5'h00
`define PTM_RST_PERIOD  8'hFF
`define PTM_RST_PWCMP   8'h00
`define PTM_RST_COUNT   8'h00

// Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
`define PTM_PRE_1       6'h00
`define PTM_PRE_4       6'h03
`define PTM_PRE_16      6'h0F
`define PTM_PRE_64      6'h3F

`endif

/* File: ptm_pkg.sv */
// Types shared by the period timer
// Assumes ptm_cfg.svh sits in the include path
package ptm_pkg;

   // Mode classes held in the upper mode bits
   typedef enum logic [1:0] {
      PTM_CLS_FREE = 2'h0,
      PTM_CLS_ONE  = 2'h1,
      PTM_CLS_MONO = 2'h2,
      PTM_CLS_RSVD = 2'h3
   } ptm_cls_t;

   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } ptm_bus_req_t;

   // Whole state of the timer
   typedef struct packed {
      logic       ers_s1;
      logic       ers_s2;
      logic       ers_s3;
      logic       ers_lvl;
      logic       ers_t1;
      logic       ers_t2;
      logic       ers_prev;
      logic       on_reg;
      logic       on_t1;
      logic       on_t2;
      logic [4:0] mode;
      logic       instr_clk;
      logic [1:0] pre_sel;
      logic [3:0] post_sel;
      logic [7:0] period;
      logic [7:0] pwcmp;
      logic [7:0] count;
      logic [5:0] pre_cnt;
      logic [3:0] post_cnt;
      logic       armed;
      logic       pwm;
      logic       post_pulse;
      logic [7:0] rdata;
   } ptm_state_t;

endpackage

/* File: ptm_timer.sv */
// Period timer with gate, limit, one-shot and monostable modes
// Assumes one core clock; external reset pin is asynchronous to it
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "ptm_cfg.svh"

// Overview of operation
// - Edge modes need fresh edge after re-enable
// - One-shot match clears enable, count zero
// - Monostable match stops at zero, enable kept
// - Zero scale selects give 1:1 division
// - Enable and pin take two timer clocks
// - Instruction clock: one clock sync delay
// - Software gate counts only while enabled
// - Free modes wrap to zero after match
// - Hardware gate halts on pin level
// - Gated count freezes, stretching PWM phases
// - Edge limit modes reset count on edge
// - Early edge reset restarts PWM pulse
// - Level limit modes hold count reset
// - Level reset ignored while enable clear
// - Level reset acts after sync delay
// - Free modes restart after match; level modes after release
// - PWM high at start, low at compare
// - Reset during high phase keeps PWM high
module ptm_timer
   import ptm_pkg::*;
(
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   // Register port
   input  wire ptm_bus_req_t bus_i,
   output logic [7:0]        rd_data_o,
   // External reset or gate pin
   input  wire logic         external_reset_input_i,
   // Time base outputs
   output logic [7:0]        count_value_o,
   output logic              pwm_out_o,
   output logic              postscaled_match_o,
   output logic              run_enable_o
);

   ptm_state_t r_reg;
   ptm_state_t r_next;

   // Prescaler terminal count per select code
   function automatic logic [5:0] pre_lim(input logic [1:0] sel);
      unique case (sel)
         2'h0: pre_lim = `PTM_PRE_1;
         2'h1: pre_lim = `PTM_PRE_4;
         2'h2: pre_lim = `PTM_PRE_16;
         2'h3: pre_lim = `PTM_PRE_64;
      endcase
   endfunction

   // Edge select: 1 rising, 2 falling, 3 either
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic rise, input logic fall);
      unique case (sel)
         2'h1: edge_hit = rise;
         2'h2: edge_hit = fall;
         2'h3: edge_hit = rise | fall;
         2'h0: edge_hit = 1'b0;
      endcase
   endfunction

   // Timer tick from the prescaler
   logic tick_c;
   assign tick_c = (r_reg.pre_cnt == pre_lim(r_reg.pre_sel));

   // Synchronised views; instruction clock skips one stage
   logic on_e;
   logic ers_e;
   logic rise_c;
   logic fall_c;
   assign on_e   = r_reg.instr_clk ? r_reg.on_t1 : r_reg.on_t2;
   assign ers_e  = r_reg.instr_clk ? r_reg.ers_t1 : r_reg.ers_t2;
   assign rise_c = ers_e & ~r_reg.ers_prev;
   assign fall_c = ~ers_e & r_reg.ers_prev;

   // Mode decode: run, reset and start qualifiers
   ptm_cls_t cls_c;
   logic [2:0] sub_c;
   logic run_c;
   logic rst_c;
   logic qual_c;
   logic lvl_c;
   assign cls_c = ptm_cls_t'(r_reg.mode[4:3]);
   assign sub_c = r_reg.mode[2:0];

   always_comb begin
      run_c  = 1'b0;
      rst_c  = 1'b0;
      qual_c = 1'b0;
      lvl_c  = 1'b0;
      unique case (cls_c)
         PTM_CLS_FREE: begin
            unique case (sub_c)
               3'h0: run_c = on_e;
               3'h1: run_c = on_e & ~ers_e;
               3'h2: run_c = on_e & ers_e;
               3'h3: begin
                  run_c = on_e;
                  rst_c = on_e & (rise_c | fall_c);
               end
               3'h4: begin
                  run_c = on_e;
                  rst_c = on_e & rise_c;
               end
               3'h5: begin
                  run_c = on_e;
                  rst_c = on_e & fall_c;
               end
               3'h6: begin
                  run_c = on_e;
                  rst_c = on_e & ~ers_e;
                  lvl_c = 1'b1;
               end
               3'h7: begin
                  run_c = on_e;
                  rst_c = on_e & ers_e;
                  lvl_c = 1'b1;
               end
            endcase
         end
         PTM_CLS_ONE: begin
            run_c = on_e & r_reg.armed;
            unique case (sub_c)
               3'h0: qual_c = 1'b1;
               3'h4: begin
                  qual_c = rise_c;
                  rst_c  = run_c & rise_c;
               end
               3'h5: begin
                  qual_c = fall_c;
                  rst_c  = run_c & fall_c;
               end
               3'h6: begin
                  qual_c = rise_c;
                  rst_c  = run_c & ~ers_e;
                  lvl_c  = 1'b1;
               end
               3'h7: begin
                  qual_c = fall_c;
                  rst_c  = run_c & ers_e;
                  lvl_c  = 1'b1;
               end
               default: qual_c = edge_hit(sub_c[1:0], rise_c, fall_c);
            endcase
         end
         PTM_CLS_MONO: begin
            run_c  = on_e & r_reg.armed;
            qual_c = ~sub_c[2] & edge_hit(sub_c[1:0], rise_c, fall_c);
         end
         PTM_CLS_RSVD: run_c = 1'b0;
      endcase
   end

   // Control register write decode
   logic wr_ctrl_c;
   assign wr_ctrl_c = bus_i.wr && (bus_i.addr == `PTM_ADDR_CTRL);

   // Next-state logic
   always_comb begin
      r_next = r_reg;
      r_next.post_pulse = 1'b0;

      // Pin synchroniser; a change counts when stages two and three agree
      r_next.ers_s1 = external_reset_input_i;
      r_next.ers_s2 = r_reg.ers_s1;
      r_next.ers_s3 = r_reg.ers_s2;
      if (r_reg.ers_s2 == r_reg.ers_s3) begin
         r_next.ers_lvl = r_reg.ers_s3;
      end

      // Prescaler
      r_next.pre_cnt = tick_c ? 6'h00 : r_reg.pre_cnt + 6'h01;

      // Timer logic runs on the tick only
      if (tick_c) begin
         // Two tick stages before detection; one with the instruction clock
         r_next.ers_t1   = r_reg.ers_lvl;
         r_next.ers_t2   = r_reg.ers_t1;
         r_next.on_t1    = r_reg.on_reg;
         r_next.on_t2    = r_reg.on_t1;
         r_next.ers_prev = ers_e;

         // Start arming; dropping enable forgets the start edge
         if (cls_c != PTM_CLS_FREE) begin
            if (!on_e) begin
               r_next.armed = 1'b0;
            end else if (!r_reg.armed && qual_c) begin
               r_next.armed = 1'b1;
               r_next.pwm   = 1'b1;
            end
         end

         if (rst_c) begin
            // Hold at zero; a high PWM phase is left as it is
            r_next.count = 8'h00;
            if (!lvl_c) begin
               r_next.pwm = 1'b1;
            end
         end else if (run_c) begin
            if (lvl_c && r_reg.ers_prev != ers_e) begin
               r_next.pwm = 1'b1;
            end
            if (r_reg.count == r_reg.period) begin
               r_next.count = 8'h00;
               // Postscaler counts period matches
               if (r_reg.post_cnt == r_reg.post_sel) begin
                  r_next.post_cnt   = 4'h0;
                  r_next.post_pulse = 1'b1;
               end else begin
                  r_next.post_cnt = r_reg.post_cnt + 4'h1;
               end
               unique case (cls_c)
                  PTM_CLS_FREE: r_next.pwm = 1'b1;
                  PTM_CLS_ONE: begin
                     r_next.on_reg = 1'b0;
                     r_next.on_t1  = 1'b0;
                     r_next.on_t2  = 1'b0;
                     r_next.armed  = 1'b0;
                  end
                  PTM_CLS_MONO: r_next.armed = 1'b0;
                  PTM_CLS_RSVD: r_next.armed = 1'b0;
               endcase
            end else begin
               r_next.count = r_reg.count + 8'h01;
               if (r_reg.count == r_reg.pwcmp) begin
                  r_next.pwm = 1'b0;
               end
            end
         end
      end

      // Software writes; a written enable beats the hardware clear
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            `PTM_ADDR_CTRL: begin
               r_next.on_reg = bus_i.wdata[`PTM_CTRL_ON];
               r_next.mode   = bus_i.wdata[`PTM_CTRL_MODE_H:`PTM_CTRL_MODE_L];
            end
            `PTM_ADDR_SCALE: begin
               r_next.pre_sel   = bus_i.wdata[`PTM_SCL_PRE_H:`PTM_SCL_PRE_L];
               r_next.post_sel  = bus_i.wdata[`PTM_SCL_POST_H:`PTM_SCL_POST_L];
               r_next.instr_clk = bus_i.wdata[`PTM_SCL_INSTR];
            end
            `PTM_ADDR_PERIOD: r_next.period = bus_i.wdata;
            `PTM_ADDR_PWCMP:  r_next.pwcmp  = bus_i.wdata;
            default: r_next.period = r_next.period;
         endcase
      end

      // Read data stand for one cycle only; unmapped reads as zero
      r_next.rdata = 8'h00;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            `PTM_ADDR_CTRL:
               r_next.rdata = {r_reg.on_reg, 2'h0, r_reg.mode};
            `PTM_ADDR_SCALE:
               r_next.rdata = {1'b0, r_reg.instr_clk, r_reg.post_sel,
                               r_reg.pre_sel};
            `PTM_ADDR_PERIOD: r_next.rdata = r_reg.period;
            `PTM_ADDR_COUNT:  r_next.rdata = r_reg.count;
            `PTM_ADDR_PWCMP:  r_next.rdata = r_reg.pwcmp;
            `PTM_ADDR_STATUS:
               r_next.rdata = {4'h0, on_e, r_reg.ers_lvl, r_reg.armed,
                               r_reg.pwm};
            default: r_next.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r_reg        <= '0;
         r_reg.mode   <= `PTM_RST_MODE;
         r_reg.period <= `PTM_RST_PERIOD;
         r_reg.pwcmp  <= `PTM_RST_PWCMP;
         r_reg.count  <= `PTM_RST_COUNT;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from state flops
   assign rd_data_o          = r_reg.rdata;
   assign count_value_o      = r_reg.count;
   assign pwm_out_o          = r_reg.pwm;
   assign postscaled_match_o = r_reg.post_pulse;
   assign run_enable_o       = r_reg.on_reg;

   // Checks on the counting behaviour
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sw_gate_hold_a: assert property (
      tick_c && r_reg.mode == 5'h00 && !on_e |=> $stable(r_reg.count))
      else $error("count moved while disabled");

   sw_gate_step_a: assert property (
      tick_c && r_reg.mode == 5'h00 && on_e && r_reg.count != r_reg.period
      |=> r_reg.count == $past(r_reg.count) + 8'h01)
      else $error("count did not advance");

   free_wrap_a: assert property (
      tick_c && cls_c == PTM_CLS_FREE && run_c && !rst_c
      && r_reg.count == r_reg.period |=> r_reg.count == 8'h00)
      else $error("no wrap after period match");

   oneshot_end_a: assert property (
      tick_c && cls_c == PTM_CLS_ONE && run_c && !rst_c && !wr_ctrl_c
      && r_reg.count == r_reg.period |=> !r_reg.on_reg && r_reg.count == 8'h00)
      else $error("one-shot did not stop");

   mono_end_a: assert property (
      tick_c && cls_c == PTM_CLS_MONO && run_c && !wr_ctrl_c
      && r_reg.count == r_reg.period
      |=> r_reg.on_reg && !r_reg.armed && r_reg.count == 8'h00)
      else $error("monostable did not stop");

   hw_gate_a: assert property (
      tick_c && r_reg.mode == 5'h01 && ers_e |=> $stable(r_reg.count))
      else $error("gated count moved");

   level_hold_a: assert property (
      tick_c && r_reg.mode == 5'h07 && on_e && ers_e |=> r_reg.count == 8'h00)
      else $error("level reset not held");

   level_off_a: assert property (
      tick_c && r_reg.mode[4:1] == 4'h3 && !on_e |=> $stable(r_reg.count))
      else $error("level reset acted while off");

   edge_reset_a: assert property (
      tick_c && r_reg.mode == 5'h04 && on_e && rise_c
      |=> r_reg.count == 8'h00 && r_reg.pwm)
      else $error("edge reset missed");

   rearm_edge_a: assert property (
      tick_c && cls_c != PTM_CLS_FREE && !on_e |=> !r_reg.armed)
      else $error("start survived disable");

   pwm_compare_a: assert property (
      tick_c && run_c && !rst_c && r_reg.count == r_reg.pwcmp
      && r_reg.count != r_reg.period && !(r_reg.armed == 1'b0 && qual_c && on_e
      && cls_c != PTM_CLS_FREE) |=> !r_reg.pwm)
      else $error("pwm not cleared at compare");

   wrap_cover: cover property (
      tick_c && cls_c == PTM_CLS_FREE && run_c && r_reg.count == r_reg.period);
   oneshot_cover: cover property (
      tick_c && cls_c == PTM_CLS_ONE && run_c && r_reg.count == r_reg.period);
   level_cover: cover property (tick_c && lvl_c && rst_c ##1 tick_c && !rst_c);
   edge_cover: cover property (tick_c && rst_c && !lvl_c);

endmodule

/* File: ptm_pin_src.sv */
// Far-side model: source of the external reset/gate pin
// Assumes the bench requests levels; the pin is asynchronous to the core
`timescale 1ns/1ps
module ptm_pin_src (
   // Level request from the bench
   input  wire logic req_level_i,
   input  wire logic slow_i,
   // Push-pull pin towards the timer
   output logic      pin_o
);
   initial pin_o = 1'b0;

   // Off-grid skew so edges never line up with the core clock
   always @(req_level_i) begin
      if (slow_i) begin
         pin_o <= #13.3 req_level_i;
      end else begin
         pin_o <= #1.7 req_level_i;
      end
   end
endmodule

/* File: period_timer_gate_limit_modes_tb_top.sv */
// Self-checking bench for the period timer modes
// Assumes ptm_pkg, ptm_timer, ptm_pin_src and ptm_cfg.svh alongside
`timescale 1ns/1ps
`include "ptm_cfg.svh"
module period_timer_gate_limit_modes_tb_top
   import ptm_pkg::*;
();
   // Stimulus and observed signals
   logic         core_clk    = 1'b0;
   logic         rst         = 1'b1;
   ptm_bus_req_t bus         = '0;
   logic         pin_req     = 1'b0;
   logic         pin_slow    = 1'b0;
   logic         pin;
   logic [7:0]   rd_data;
   logic [7:0]   cnt;
   logic         pwm;
   logic         pmatch;
   logic         run_en;
   int           n_mismatch  = 0;
   int           checks_done = 0;

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   // Timer under test
   ptm_timer u_ptm_timer (
      .core_clk_i             (core_clk),
      .rst_i                  (rst),
      .bus_i                  (bus),
      .rd_data_o              (rd_data),
      .external_reset_input_i (pin),
      .count_value_o          (cnt),
      .pwm_out_o              (pwm),
      .postscaled_match_o     (pmatch),
      .run_enable_o           (run_en)
   );

   // External pin source
   ptm_pin_src u_ptm_pin_src (
      .req_level_i (pin_req),
      .slow_i      (pin_slow),
      .pin_o       (pin)
   );

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Settle one time unit past the edge so registered outputs have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic do_reset(input int n);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (n) @(posedge core_clk);
      rst <= 1'b0;
   endtask

   task automatic set_pin(input logic v);
      @(posedge core_clk);
      pin_req <= v;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus.wr    <= 1'b1;
      bus.addr  <= a;
      bus.wdata <= d;
      @(posedge core_clk);
      bus.wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus.rd   <= 1'b1;
      bus.addr <= a;
      @(posedge core_clk);
      bus.rd   <= 1'b0;
      #1;
      d = rd_data;
   endtask

   // Bounded wait for a count value
   task automatic wait_cnt(input logic [7:0] v, input int lim);
      for (int i = 0; i < lim; i++) begin
         cyc(1);
         if (cnt === v) break;
      end
      chk("count reached", v, cnt);
   endtask

   task automatic t_regs;
      logic [7:0] d;
      logic [7:0] exp [7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      do_reset(2);
      for (int a = 0; a < 7; a++) begin
         rd(3'(a), d);
         chk("reset value", exp[a], d);
      end
      wr(`PTM_ADDR_COUNT, 8'h55);
      rd(`PTM_ADDR_COUNT, d);
      chk("count read-only", 8'h00, d);
      wr(`PTM_ADDR_SCALE, 8'h3C);
      rd(`PTM_ADDR_SCALE, d);
      chk("scale readback", 8'h3C, d);
      $display("test registers done");
   endtask

   task automatic t_soft;
      logic [7:0] c;
      int         n;
      do_reset(2);
      wr(`PTM_ADDR_PERIOD, 8'h03);
      wr(`PTM_ADDR_CTRL, 8'h80);
      cyc(2);
      chk("count during sync", 8'h00, cnt);
      wait_cnt(8'h03, 8);
      cyc(1);
      chk("wrap after match", 8'h00, cnt);
      n = 0;
      repeat (12) begin
         cyc(1);
         n += int'(pmatch === 1'b1);
      end
      chk("match pulses", 8'h03, 8'(n));
      wr(`PTM_ADDR_SCALE, 8'h01);
      cyc(8);
      c = cnt;
      cyc(4);
      chk("prescaled step", (c == 8'h03) ? 8'h00 : c + 8'h01, cnt);
      wr(`PTM_ADDR_CTRL, 8'h00);
      cyc(20);
      c = cnt;
      cyc(12);
      chk("held while off", c, cnt);
      $display("test software gate done");
   endtask

   task automatic t_gate;
      logic [7:0] c;
      for (int m = 1; m <= 2; m++) begin
         do_reset(2);
         set_pin(m == 2);
         wr(`PTM_ADDR_PERIOD, 8'h0C);
         wr(`PTM_ADDR_PWCMP, 8'h08);
         wr(`PTM_ADDR_CTRL, 8'h80 | 8'(m));
         wait_cnt(8'h0C, 30);
         set_pin(m == 1);
         cyc(10);
         c = cnt;
         cyc(8);
         chk("gated count", c, cnt);
         chk("pwm stretched", 8'h01, {7'h00, pwm});
         set_pin(m == 2);
         wait_cnt(8'h0A, 20);
         chk("pwm after compare", 8'h00, {7'h00, pwm});
      end
      $display("test hardware gate done");
   endtask

   task automatic t_edge;
      for (int m = 3; m <= 5; m++) begin
         do_reset(2);
         set_pin(1'b0);
         wr(`PTM_ADDR_PERIOD, 8'hC8);
         wr(`PTM_ADDR_PWCMP, 8'h20);
         wr(`PTM_ADDR_CTRL, 8'h80 | 8'(m));
         wait_cnt(8'h28, 60);
         set_pin(1'b1);
         cyc(10);
         chk("reset on rise", {7'h00, m != 5}, {7'h00, cnt < 8'h14});
         chk("pwm after rise", {7'h00, m != 5}, {7'h00, pwm});
         cyc(30);
         set_pin(1'b0);
         cyc(10);
         chk("reset on fall", {7'h00, m != 4}, {7'h00, cnt < 8'h14});
         chk("pwm after fall", {7'h00, m != 4}, {7'h00, pwm});
      end
      $display("test edge limit done");
   endtask

   task automatic t_level;
      logic [7:0] c;
      for (int m = 6; m <= 7; m++) begin
         do_reset(2);
         pin_slow <= (m == 7);
         set_pin(m == 7);
         wr(`PTM_ADDR_PERIOD, 8'h32);
         wr(`PTM_ADDR_PWCMP, 8'h10);
         wr(`PTM_ADDR_CTRL, 8'h80 | 8'(m));
         cyc(12);
         chk("held in reset", 8'h00, cnt);
         set_pin(m == 6);
         wait_cnt(8'h03, 14);
         chk("pwm at start", 8'h01, {7'h00, pwm});
         set_pin(m == 7);
         wait_cnt(8'h00, 14);
         cyc(6);
         chk("pwm held in reset", 8'h01, {7'h00, pwm});
         set_pin(m == 6);
         wait_cnt(8'h12, 30);
         chk("pwm after compare", 8'h00, {7'h00, pwm});
         wr(`PTM_ADDR_CTRL, 8'(m));
         cyc(8);
         c = cnt;
         set_pin(m == 7);
         cyc(16);
         chk("pin ignored when off", c, cnt);
      end
      $display("test level limit done");
   endtask

   task automatic t_shot;
      logic [7:0] c;
      // Software-start one-shot
      do_reset(2);
      wr(`PTM_ADDR_PERIOD, 8'h04);
      wr(`PTM_ADDR_CTRL, 8'h88);
      wait_cnt(8'h04, 12);
      cyc(1);
      chk("one-shot clears on", 8'h00, {7'h00, run_en});
      cyc(8);
      chk("one-shot stop", 8'h00, cnt);
      // Rising-edge monostable
      do_reset(2);
      set_pin(1'b0);
      wr(`PTM_ADDR_PERIOD, 8'h04);
      wr(`PTM_ADDR_CTRL, 8'h91);
      cyc(10);
      chk("waits for edge", 8'h00, cnt);
      set_pin(1'b1);
      wait_cnt(8'h04, 16);
      cyc(1);
      chk("mono stop", 8'h00, cnt);
      chk("mono keeps on", 8'h01, {7'h00, run_en});
      cyc(8);
      chk("mono stays", 8'h00, cnt);
      // Edge one-shot paused and re-enabled mid-count
      do_reset(2);
      set_pin(1'b0);
      wr(`PTM_ADDR_PERIOD, 8'h64);
      wr(`PTM_ADDR_CTRL, 8'h89);
      set_pin(1'b1);
      wait_cnt(8'h05, 20);
      wr(`PTM_ADDR_CTRL, 8'h09);
      cyc(6);
      wr(`PTM_ADDR_CTRL, 8'h89);
      cyc(10);
      c = cnt;
      cyc(6);
      chk("no resume without edge", c, cnt);
      set_pin(1'b0);
      cyc(8);
      set_pin(1'b1);
      wait_cnt(c + 8'h03, 20);
      // Reserved mode never counts
      do_reset(2);
      wr(`PTM_ADDR_CTRL, 8'h98);
      cyc(12);
      chk("reserved idle", 8'h00, cnt);
      $display("test one-shot and monostable done");
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      t_regs;
      t_soft;
      t_gate;
      t_edge;
      t_level;
      t_shot;
      close_out;
   end

   // Watchdog far beyond the thousand or so cycles the tests need
   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
endmodule
